// ===== shared/bbos_pkg.sv
// Contract
// R01: The main code block is 64 kB, organised as 512 sectors of 128 bytes.
// R02: A second block holds the programming routines and can overlay the lowest 8 kB.
// R03: Fetches from 0000h to 1FFFh go to the boot block only when both mapping bits are 0.
// R04: Clearing the bank-select bit exposes the boot routines only while soft-reset is clear.
// R05: After power-on the boot code runs, then hands over to user code after about 400 ms.
// R06: The hand-over is a software reset, which leaves the soft-reset bit set.
// R07: Software must not clear bank-select while it runs from 0000h to 1FFFh.
// R08: Once the oscillator runs, the reset sequence weakly pulls all port pins high.
// R09: A system reset while running leaves data RAM unchanged; the code drops ram_preserve on an external reset.
// R10: The reset pin must stay high until the oscillator runs plus two machine cycles.
// R11: Unused register bits read undefined, reset to zero and must not be written with ones.
// R12: Power-on or external reset forces the two mapping bits to 00.
// R13: Writing soft-reset from 0 to 1 resets the program counter to 0 and sets the bits to 10.
// R14: Watchdog and brown-out resets clear bank-select and keep soft-reset.
// R15: A change of a mapping bit applies from the next instruction fetch onward.
package bbos_pkg;

    localparam int          MAIN_BYTES       = 65536;
    localparam int          SECTOR_BYTES     = 128;
    localparam int          SECTOR_COUNT     = 512;
    localparam int          BOOT_BYTES       = 8192;
    localparam int          RAM_BYTES        = 1024;
    localparam logic [15:0] BOOT_TOP_ADDR    = 16'h1FFF;
    localparam logic [15:0] RESET_VECTOR     = 16'h0000;
    localparam logic [1:0]  MAP_AFTER_POR    = 2'h0;
    localparam logic [1:0]  MAP_AFTER_SWRST  = 2'h2;
    localparam int          MAP_SOFT_POS     = 1;
    localparam int          MAP_BANK_POS     = 0;
    localparam logic [7:0]  CFG_USED_MASK    = 8'h03;
    localparam int          CLK_MHZ          = 200;
    localparam int          CLKS_PER_MCYCLE  = 12;
    localparam int          POR_EXTRA_MCYC   = 2;
    localparam int          POR_EXTRA_CLKS   = POR_EXTRA_MCYC * CLKS_PER_MCYCLE;
    localparam int          AUTOBAUD_MS      = 400;
    localparam longint      AUTOBAUD_CLKS    = longint'(AUTOBAUD_MS) * 1000 * CLK_MHZ;

    typedef enum {
        BBOS_ST_HOLD,
        BBOS_ST_SETTLE,
        BBOS_ST_BOOT,
        BBOS_ST_RUN
    } bbos_state_type;

    typedef struct packed {
        logic        valid;
        logic        first;
        logic [15:0] addr;
    } bbos_fetch_type;

    typedef struct packed {
        logic        valid;
        logic        boot_sel;
        logic [15:0] addr;
    } bbos_route_type;

endpackage

// ===== rtl/bbos_map.sv
`timescale 1ns/100ps
module bbos_map (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic [1:0]              map_bits,
    input  wire bbos_pkg::bbos_fetch_type fetch,
    output bbos_pkg::bbos_route_type      route
);
    logic [1:0] insn_map;
    logic [1:0] use_map;
    logic       boot_sel;

    // latch mapping at instruction start only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            insn_map <= bbos_pkg::MAP_AFTER_POR;
        end else if (fetch.valid && fetch.first) begin
            insn_map <= map_bits; // [R15]
        end
    end

    assign use_map  = (fetch.valid && fetch.first) ? map_bits : insn_map; // [R15]
    assign boot_sel = (use_map == 2'h0) && (fetch.addr <= bbos_pkg::BOOT_TOP_ADDR); // [R03] [R04]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route <= '0;
        end else begin
            route.valid    <= fetch.valid;
            route.boot_sel <= fetch.valid && boot_sel; // [R02] [R03]
            route.addr     <= fetch.addr;
        end
    end

    property p_r03_high_main;
        @(posedge clk) disable iff (!rst_n)
            fetch.valid && (fetch.addr > bbos_pkg::BOOT_TOP_ADDR) |=> !route.boot_sel;
    endproperty
    a_r03_high_main: assert property (p_r03_high_main) else $error("high address to boot"); // [R03]

    property p_r04_needs_both_clear;
        @(posedge clk) disable iff (!rst_n)
            fetch.valid && fetch.first && (map_bits != 2'h0) |=> !route.boot_sel;
    endproperty
    a_r04_needs_both_clear: assert property (p_r04_needs_both_clear) else $error("boot w/ bit"); // [R04]

    property p_r15_hold_in_insn;
        @(posedge clk) disable iff (!rst_n)
            fetch.valid && !fetch.first |-> use_map == $past(use_map);
    endproperty
    a_r15_hold_in_insn: assert property (p_r15_hold_in_insn) else $error("map changed mid insn"); // [R15]
endmodule

// ===== rtl/bbos_top.sv
`timescale 1ns/100ps
module bbos_top #(
    parameter longint AUTOBAUD_CLKS = bbos_pkg::AUTOBAUD_CLKS,
    parameter int     SECTORS       = bbos_pkg::SECTOR_COUNT
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     rst_pin,
    input  wire logic                     osc_ready,
    input  wire logic                     wdt_reset,
    input  wire logic                     bod_reset,
    input  wire logic                     cfg_we,
    input  wire logic [7:0]               cfg_wdata,
    input  wire logic                     autobaud_ok,
    input  wire logic                     emulation_flag,
    input  wire bbos_pkg::bbos_fetch_type fetch,
    output bbos_pkg::bbos_route_type      route,
    output logic [7:0]                    flash_config_reg,
    output logic                          core_reset,
    output logic                          pc_reload,
    output logic                          ram_preserve,
    output logic                          port_pullup,
    output logic                          in_system_programming_mode,
    output logic [8:0]                    sector_index
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic [1:0] osc_sync;
    logic       ext_rst;
    logic       osc_ok;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_sync <= 2'h3;
            osc_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], rst_pin};
            osc_sync <= {osc_sync[0], osc_ready};
        end
    end
    assign ext_rst = rst_sync[1];
    assign osc_ok  = osc_sync[1];

    // ------------------------------------------------------------
    // power-on sequence
    // ------------------------------------------------------------
    bbos_pkg::bbos_state_type state;
    logic [7:0]  settle_cnt;
    logic [39:0] boot_cnt;
    logic        sw_reset;
    logic        handover;

    assign sw_reset = cfg_we && cfg_wdata[bbos_pkg::MAP_SOFT_POS]
                      && !flash_config_reg[bbos_pkg::MAP_SOFT_POS]; // [R13]
    assign handover = (state == bbos_pkg::BBOS_ST_BOOT) && !autobaud_ok && !emulation_flag
                      && (boot_cnt >= 40'(AUTOBAUD_CLKS - 1)); // [R05]

    always_ff @(posedge clk) begin
        if (!rst_n || ext_rst) begin
            state      <= bbos_pkg::BBOS_ST_HOLD;
            settle_cnt <= 8'h00;
            boot_cnt   <= 40'h0;
        end else begin
            case (state)
                bbos_pkg::BBOS_ST_HOLD: begin
                    if (osc_ok) begin
                        state <= bbos_pkg::BBOS_ST_SETTLE; // [R10]
                    end
                end
                bbos_pkg::BBOS_ST_SETTLE: begin
                    settle_cnt <= settle_cnt + 8'h01;
                    if (settle_cnt >= 8'(bbos_pkg::POR_EXTRA_CLKS - 1)) begin
                        state <= bbos_pkg::BBOS_ST_BOOT; // [R10]
                    end
                end
                bbos_pkg::BBOS_ST_BOOT: begin
                    if (autobaud_ok || sw_reset || handover) begin
                        state <= bbos_pkg::BBOS_ST_RUN; // [R05] [R06]
                    end else begin
                        boot_cnt <= boot_cnt + 40'h1;
                    end
                end
                bbos_pkg::BBOS_ST_RUN: begin
                    state <= bbos_pkg::BBOS_ST_RUN;
                end
                default: begin
                    state <= bbos_pkg::BBOS_ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || ext_rst) begin
            in_system_programming_mode <= 1'b0;
        end else if (state == bbos_pkg::BBOS_ST_BOOT && autobaud_ok) begin
            in_system_programming_mode <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // mapping bits
    // ------------------------------------------------------------
    logic [1:0] map_bits;
    logic       hw_reset;

    assign hw_reset = !rst_n || ext_rst || (state != bbos_pkg::BBOS_ST_BOOT
                      && state != bbos_pkg::BBOS_ST_RUN);

    always_ff @(posedge clk) begin
        if (hw_reset) begin
            map_bits <= bbos_pkg::MAP_AFTER_POR; // [R12]
        end else if (sw_reset || handover) begin
            map_bits <= bbos_pkg::MAP_AFTER_SWRST; // [R06] [R13]
        end else if (wdt_reset || bod_reset) begin
            map_bits[bbos_pkg::MAP_BANK_POS] <= 1'b0; // [R14]
        end else if (cfg_we) begin
            map_bits <= cfg_wdata[1:0] & bbos_pkg::CFG_USED_MASK[1:0]; // [R11]
        end
    end

    // unused bits read zero
    assign flash_config_reg = {6'h00, map_bits}; // [R11]

    // ------------------------------------------------------------
    // core reset, pins, ram
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_reset   <= 1'b1;
            pc_reload    <= 1'b0;
            port_pullup  <= 1'b0;
            ram_preserve <= 1'b0;
        end else begin
            core_reset   <= hw_reset || sw_reset || handover || wdt_reset || bod_reset;
            pc_reload    <= sw_reset || handover || wdt_reset || bod_reset; // [R13]
            port_pullup  <= osc_ok && (state != bbos_pkg::BBOS_ST_RUN
                            && state != bbos_pkg::BBOS_ST_BOOT); // [R08]
            ram_preserve <= (state == bbos_pkg::BBOS_ST_RUN
                            || state == bbos_pkg::BBOS_ST_BOOT) && !ext_rst; // [R09]
        end
    end

    // ------------------------------------------------------------
    // fetch routing
    // ------------------------------------------------------------
    bbos_map u_map (
        .clk      (clk),
        .rst_n    (rst_n),
        .map_bits (map_bits),
        .fetch    (fetch),
        .route    (route)
    );

    // 128-byte sectors of main block
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sector_index <= 9'h000;
        end else begin
            sector_index <= 9'(fetch.addr >> $clog2(bbos_pkg::MAIN_BYTES / SECTORS)); // [R01]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_r12_por_map;
        @(posedge clk) disable iff (!rst_n)
            ext_rst |=> map_bits == 2'h0;
    endproperty
    a_r12_por_map: assert property (p_r12_por_map) else $error("map not 00 after reset"); // [R12]

    sequence s_sw_write;
        sw_reset && !hw_reset;
    endsequence
    property p_r13_swrst;
        @(posedge clk) disable iff (!rst_n)
            s_sw_write |=> (map_bits == 2'h2) ##0 pc_reload;
    endproperty
    a_r13_swrst: assert property (p_r13_swrst) else $error("sw reset wrong map"); // [R13]

    property p_r14_wdt_keeps_soft;
        @(posedge clk) disable iff (!rst_n)
            (wdt_reset || bod_reset) && !hw_reset && !sw_reset && !handover
            |=> !map_bits[0] && map_bits[1] == $past(map_bits[1]);
    endproperty
    a_r14_wdt_keeps_soft: assert property (p_r14_wdt_keeps_soft) else $error("wdt map"); // [R14]

    property p_r05_handover;
        @(posedge clk) disable iff (!rst_n)
            handover && !ext_rst |=> state == bbos_pkg::BBOS_ST_RUN && map_bits == 2'h2;
    endproperty
    a_r05_handover: assert property (p_r05_handover) else $error("no handover"); // [R05] [R06]

    property p_r10_settle;
        @(posedge clk) disable iff (!rst_n)
            $rose(state == bbos_pkg::BBOS_ST_BOOT) |-> $past(state == bbos_pkg::BBOS_ST_SETTLE);
    endproperty
    a_r10_settle: assert property (p_r10_settle) else $error("boot without settle"); // [R10]

    property p_r11_unused_zero;
        @(posedge clk) disable iff (!rst_n)
            cfg_we && !hw_reset && !sw_reset && !handover && !wdt_reset && !bod_reset
            |=> flash_config_reg == {6'h00, $past(cfg_wdata[1:0])};
    endproperty
    a_r11_unused_zero: assert property (p_r11_unused_zero) else $error("unused bits set"); // [R11]

    property p_r08_pullup_needs_osc;
        @(posedge clk) disable iff (!rst_n)
            !osc_ok |=> !port_pullup;
    endproperty
    a_r08_pullup_needs_osc: assert property (p_r08_pullup_needs_osc) else $error("early pull"); // [R08]

    property p_r09_keep_ram;
        @(posedge clk) disable iff (!rst_n)
            (wdt_reset || bod_reset || sw_reset) && state == bbos_pkg::BBOS_ST_RUN && !ext_rst
            |=> ram_preserve;
    endproperty
    a_r09_keep_ram: assert property (p_r09_keep_ram) else $error("ram lost on reset"); // [R09]

    property p_r10_core_held;
        @(posedge clk) disable iff (!rst_n)
            hw_reset |=> core_reset;
    endproperty
    a_r10_core_held: assert property (p_r10_core_held) else $error("core not held"); // [R10]
endmodule

// ===== bench/bbos_reset_src.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// external reset source with slow oscillator start
// ----------------------------------------------------------------
module bbos_reset_src #(
    parameter int OSC_CLKS = 20
) (
    input  wire logic clk,
    input  wire logic por_req,
    output logic      rst_pin,
    output logic      osc_ready
);
    initial begin
        rst_pin   = 1'b0;
        osc_ready = 1'b1;
    end

    // pin held past oscillator start plus two machine cycles
    always @(posedge clk) begin
        if (por_req) begin
            #1 rst_pin = 1'b1;
            osc_ready = 1'b0;
            repeat (OSC_CLKS) @(posedge clk);
            #1 osc_ready = 1'b1;
            repeat (bbos_pkg::POR_EXTRA_CLKS + 2) @(posedge clk);
            #1 rst_pin = 1'b0;
        end
    end
endmodule

// ===== bench/boot_bank_overlay_select_test.sv
`timescale 1ns/100ps
module boot_bank_overlay_select_test;
    logic                     clk            = 1'b0;
    logic                     rst_n          = 1'b0;
    logic                     por_req        = 1'b0;
    logic                     wdt_reset      = 1'b0;
    logic                     bod_reset      = 1'b0;
    logic                     cfg_we         = 1'b0;
    logic [7:0]               cfg_wdata      = 8'h00;
    logic                     autobaud_ok    = 1'b1;
    logic                     emulation_flag = 1'b0;
    bbos_pkg::bbos_fetch_type fetch          = '0;
    bbos_pkg::bbos_route_type route;
    logic                     rst_pin;
    logic                     osc_ready;
    logic [7:0]               flash_config_reg;
    logic [8:0]               sector_index;
    logic                     core_reset;
    logic                     pc_reload;
    logic                     ram_preserve;
    logic                     port_pullup;
    logic                     in_system_programming_mode;
    logic [1:0]               imap           = 2'h0;
    logic [1:0]               map            = 2'h0;
    logic [31:0]              seed           = 32'h6161;
    int                       err_count      = 0;
    int                       checks_done    = 0;

    always #2.5 clk = ~clk;

    bbos_reset_src src (.clk(clk), .por_req(por_req), .rst_pin(rst_pin), .osc_ready(osc_ready));

    bbos_top #(.AUTOBAUD_CLKS(50)) uut (
        .clk(clk), .rst_n(rst_n), .rst_pin(rst_pin), .osc_ready(osc_ready),
        .wdt_reset(wdt_reset), .bod_reset(bod_reset), .cfg_we(cfg_we),
        .cfg_wdata(cfg_wdata), .autobaud_ok(autobaud_ok),
        .emulation_flag(emulation_flag), .fetch(fetch), .route(route),
        .flash_config_reg(flash_config_reg), .core_reset(core_reset), .pc_reload(pc_reload),
        .ram_preserve(ram_preserve), .port_pullup(port_pullup),
        .in_system_programming_mode(in_system_programming_mode),
        .sector_index(sector_index));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [1:0] next_map(input logic [1:0] m, input logic [7:0] w);
        return (!m[1] && w[1]) ? 2'h2 : w[1:0];
    endfunction

    function automatic logic exp_boot(input logic [1:0] m, input logic [15:0] a);
        return (m == 2'h0) && (a <= 16'h1FFF);
    endfunction

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic do_fetch(input logic [15:0] a, input logic f);
        @(posedge clk) #1 fetch = {1'b1, f, a};
        @(posedge clk) #1 fetch.valid = 1'b0;
        if (f) begin
            imap = map;
        end
        check(route.boot_sel === exp_boot(imap, a), "bank choice");
        check(route.valid === 1'b1 && route.addr === a, "route echo");
        check(sector_index === a[15:7], "sector");
    endtask

    task automatic cfg_wr(input logic [7:0] d);
        logic sw;
        sw = !map[1] && d[1];
        @(posedge clk) #1 cfg_we = 1'b1;
        cfg_wdata = d;
        @(posedge clk) #1 cfg_we = 1'b0;
        check(pc_reload === sw && core_reset === sw, "reload after write");
        map = next_map(map, d);
        repeat (40) @(posedge clk);
        check(flash_config_reg === {6'h00, map}, "config after write");
        check(ram_preserve === 1'b1, "ram kept after write");
    endtask

    task automatic hw_pulse(input logic brown);
        @(posedge clk) #1 wdt_reset = ~brown;
        bod_reset = brown;
        @(posedge clk) #1 wdt_reset = 1'b0;
        bod_reset = 1'b0;
        check(pc_reload === 1'b1 && core_reset === 1'b1, "fault reset pulse");
        map[0] = 1'b0;
        repeat (40) @(posedge clk);
        check(flash_config_reg === {6'h00, map}, "config after fault reset");
        check(ram_preserve === 1'b1 && core_reset === 1'b0, "ram after fault reset");
    endtask

    task automatic power_on(input logic [1:0] m);
        @(posedge clk) #1 por_req = 1'b1;
        @(posedge clk) #1 por_req = 1'b0;
        map = m;
        repeat (10) @(posedge clk);
        #1 check(port_pullup === 1'b0, "pull-up before oscillator");
        repeat (30) @(posedge clk);
        #1 check(port_pullup === 1'b1 && core_reset === 1'b1, "pins during reset");
        repeat (160) @(posedge clk);
        check(flash_config_reg === {6'h00, m}, "config after power-on");
        check(in_system_programming_mode === autobaud_ok, "programming mode");
        check(core_reset === 1'b0, "core released");
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        power_on(2'h0);
        do_fetch(16'h1FFF, 1'b1);
        do_fetch(16'h2000, 1'b1);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            do_fetch(seed[15:0] | 16'h2000, 1'b1);
            cfg_wr(seed[23:16]);
            do_fetch(seed[31:16] & 16'h1FFF, 1'b0);
            do_fetch(seed[31:16] & 16'h1FFF, 1'b1);
        end
        cfg_wr(8'h00);
        cfg_wr(8'h01);
        hw_pulse(1'b0);
        do_fetch(16'h0000, 1'b1);
        cfg_wr(8'h03);
        cfg_wr(8'h03);
        hw_pulse(1'b1);
        do_fetch(16'h0000, 1'b1);
        autobaud_ok = 1'b0;
        emulation_flag = 1'b1;
        power_on(2'h0);
        emulation_flag = 1'b0;
        power_on(2'h2);
        do_fetch(16'h0100, 1'b1);
        end_sim();
    end
endmodule
